// ===== hdl/erd_decoder.sv
// region decoder of the external bus unit with its register slave
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "erd_map.svh"

// Summary of operation
// [RQ1] when idle, take external-segment addresses and compare with all eight regions
// [RQ2] each address select register holds enable, base, mask, alt segment, alt enable
// [RQ3] disabled region gives bus error and keeps its chip select inactive
// [RQ4] base holds A31..A12; segments 8, 10, 13, 14, 15 only
// [RQ5] mask counts compared bits from A26 down, max 15; A31..A27 always match
// [RQ6] A31..A28 compared to base nibble and alt segment; A27 to base always
// [RQ7] alternate segment counts only when its valid bit is set
// [RQ8] region sizes from 4 KBytes up to 128 MBytes
// [RQ9] base bits below the compared range are ignored
// [RQ10] mask N compares A26 down to A(27-N); region 2^(27-N) bytes
// [RQ11] demultiplexed drives A23..A0 only, multiplexed drives all 32 bits
// [RQ12] local bus address in register space is a register access
// [RQ13] single enabled hit starts external access with that region's parameters
// [RQ14] several hits: lowest numbered region wins, 0 highest, 7 lowest
// [RQ15] no enabled hit: error acknowledge and no external access
// [RQ16] software keeps mirrored mappings free of collisions; no check here
// [RQ17] access uses global configuration plus the region's own parameters
// [RQ18] capture n, compare n+1, select n+2, start in n+3
// [RQ19] selected parameters checked against access; invalid gives error
// [RQ20] alt enable active high; emulator region is index 7
module erd_decoder
    import erd_pkg::*;
#(
    parameter logic [19:0] REG_SPACE_BASE = 20'hf8000, // A31..A12 of register page
    parameter int          NREG           = 8          // regions incl. emulator
) (
    input  wire logic        mclk_i,          // system clock
    input  wire logic        reset_i,         // async reset, high
    input  wire logic [7:0]  avs_address_i,   // byte address
    input  wire logic        avs_read_i,      // read request
    input  wire logic        avs_write_i,     // write request
    input  wire logic [31:0] avs_writedata_i, // write data
    input  wire logic [3:0]  avs_byteenable_i,// byte lanes
    output logic      [31:0] avs_readdata_o,  // read data
    output logic             avs_waitrequest_o,// stall
    input  wire logic        req_valid_i,     // bus master request
    input  wire logic [31:0] req_addr_i,      // request address
    input  wire logic        req_write_i,     // request is a write
    input  wire logic [1:0]  req_size_i,      // 8/16/32/64 bit
    input  wire logic        req_local_i,     // from local memory bus
    output logic             req_ready_o,     // decoder idle
    output logic             acc_start_o,     // external access start
    output logic             err_ack_o,       // error acknowledge
    output logic             reg_access_o,    // own register access
    output logic [2:0]       acc_region_o,    // selected region
    output logic [7:0]       acc_cs_o,        // one-hot chip select
    output logic             acc_glb_cs_o,    // global chip select
    output logic [1:0]       acc_clkdiv_o,    // bus clock prescale
    output logic [2:0]       acc_type_o,      // access type
    output logic             acc_port32_o,    // 32-bit port
    output logic             acc_bigend_o,    // big endian
    output logic             acc_write_o,     // write access
    output logic [1:0]       acc_size_o,      // access size
    output logic [31:0]      acc_addr_o       // external address
);

    function automatic logic region_hit(input logic [31:0] sel,
                                        input logic [31:0] a);
        logic [14:0] m;
        logic        base_ok;
        logic        alt_ok;
        logic        low_ok;
        m = ~(`ERD_CMP_ALL >> sel[`ERD_MASK_MSB:`ERD_MASK_LSB]); // see [RQ10]
        // see [RQ5] [RQ6]
        base_ok = a[`ERD_A_MSB:`ERD_A_FIX] == sel[`ERD_A_MSB:`ERD_A_FIX];
        alt_ok  = sel[`ERD_ALTERNATE_SEGMENT_VALID]                                 // see [RQ7]
                && a[`ERD_A_MSB:`ERD_SEG_LSB]
                   == sel[`ERD_ALTERNATE_SEGMENT_MSB:`ERD_ALTERNATE_SEGMENT_LSB]
                && a[`ERD_A_FIX] == sel[`ERD_A_FIX];
        // unmasked low bits ignored: alignment to size, see [RQ9] [RQ8]
        low_ok  = ((a[`ERD_CMP_MSB:`ERD_CMP_LSB]
                  ^ sel[`ERD_CMP_MSB:`ERD_CMP_LSB]) & m) == 15'h0000;
        region_hit = sel[`ERD_REGION_ENABLE] && (base_ok || alt_ok) && low_ok;
    endfunction

    function automatic logic seg_valid(input logic [3:0] s);
        seg_valid = (s == 4'h8) || (s == 4'ha) || (s == 4'hd)
                 || (s == 4'he) || (s == 4'hf);               // see [RQ4]
    endfunction

    function automatic erd_idx_t first_hit(input logic [7:0] h);
        first_hit = 3'h7;
        for (int i = 7; i >= 0; i--) begin
            if (h[i]) begin
                first_hit = erd_idx_t'(i);                     // see [RQ14]
            end
        end
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            o[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        be_merge = o;
    endfunction

    // register file
    logic [31:0] addsel_ff [NREG];
    logic [5:0]  busctl_ff [NREG];
    logic [9:0]  glbcfg_ff;
    logic [7:0]  errcnt_ff;
    logic [2:0]  last_idx_ff;
    logic        last_err_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;

    wire         bus_req   = avs_read_i || avs_write_i;
    wire         wr_take   = avs_write_i && !wait_ff;
    wire  [2:0]  bus_ridx  = avs_address_i[4:2];
    wire         sel_addr  = avs_address_i < `ERD_OFS_BUSCTL;
    wire         sel_bctl  = !sel_addr && avs_address_i < `ERD_OFS_GLBCFG;
    wire         sel_glb   = avs_address_i == `ERD_OFS_GLBCFG;
    wire         sel_stat  = avs_address_i == `ERD_OFS_STATUS;
    wire         nxt_wait  = !(bus_req && wait_ff);
    wire  [31:0] wr_merged = be_merge(addsel_ff[bus_ridx], avs_writedata_i,
                                      avs_byteenable_i);
    wire  [31:0] bc_merged = be_merge({26'h0, busctl_ff[bus_ridx]},
                                      avs_writedata_i, avs_byteenable_i);
    wire  [31:0] gc_merged = be_merge({22'h0, glbcfg_ff}, avs_writedata_i,
                                      avs_byteenable_i);
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (sel_addr) begin
            nxt_rdata = addsel_ff[bus_ridx];                  // see [RQ2]
        end else if (sel_bctl) begin
            nxt_rdata = {26'h0, busctl_ff[bus_ridx]};
        end else if (sel_glb) begin
            nxt_rdata = {22'h0, glbcfg_ff};
        end else if (sel_stat) begin
            nxt_rdata = {20'h0, last_err_ff, last_idx_ff, errcnt_ff};
        end
    end

    // answer comes one cycle after the request is seen; writes land then
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff  <= nxt_wait;
            if (avs_read_i && wait_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < NREG; i++) begin
                addsel_ff[i] <= `ERD_ADDSEL_RST;
                busctl_ff[i] <= `ERD_BUSCTL_RST;
            end
            glbcfg_ff <= `ERD_GLBCFG_RST;
        end else if (wr_take) begin
            if (sel_addr) begin
                addsel_ff[bus_ridx] <= wr_merged;
            end
            if (sel_bctl) begin
                busctl_ff[bus_ridx] <= bc_merged[5:0];
            end
            if (sel_glb) begin
                glbcfg_ff <= gc_merged[9:0];
            end
        end
    end

    // stage 1: address captured at end of cycle n
    logic        ready_ff;
    logic        s1_vld_ff;
    logic [31:0] s1_addr_ff;
    logic        s1_wr_ff;
    logic [1:0]  s1_size_ff;
    logic        s1_local_ff;
    wire         accept = req_valid_i && ready_ff;            // see [RQ1]

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_vld_ff   <= 1'b0;
            s1_addr_ff  <= 32'h0000_0000;
            s1_wr_ff    <= 1'b0;
            s1_size_ff  <= 2'h0;
            s1_local_ff <= 1'b0;
        end else begin
            s1_vld_ff <= accept;                              // see [RQ18]
            if (accept) begin
                s1_addr_ff  <= req_addr_i;
                s1_wr_ff    <= req_write_i;
                s1_size_ff  <= req_size_i;
                s1_local_ff <= req_local_i;
            end
        end
    end

    // stage 2: comparison in cycle n+1, all regions in parallel
    wire  [7:0]  hit;
    for (genvar g = 0; g < 8; g++) begin : g_cmp
        assign hit[g] = region_hit(addsel_ff[g], s1_addr_ff); // see [RQ20]
    end
    wire         seg_ok  = seg_valid(s1_addr_ff[`ERD_A_MSB:`ERD_SEG_LSB]);
    wire         reg_hit = s1_local_ff                        // see [RQ12]
                        && s1_addr_ff[`ERD_A_MSB:`ERD_CMP_LSB] == REG_SPACE_BASE;
    // a disabled region never hits, so it falls to the miss path
    wire         miss    = !seg_ok || hit == 8'h00;           // see [RQ3] [RQ15]

    logic        s2_vld_ff;
    logic        s2_miss_ff;
    logic        s2_reg_ff;
    erd_idx_t    s2_idx_ff;
    logic [31:0] s2_addr_ff;
    logic        s2_wr_ff;
    logic [1:0]  s2_size_ff;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s2_vld_ff  <= 1'b0;
            s2_miss_ff <= 1'b0;
            s2_reg_ff  <= 1'b0;
            s2_idx_ff  <= 3'h0;
            s2_addr_ff <= 32'h0000_0000;
            s2_wr_ff   <= 1'b0;
            s2_size_ff <= 2'h0;
        end else begin
            s2_vld_ff <= s1_vld_ff;
            if (s1_vld_ff) begin
                s2_miss_ff <= miss;
                s2_reg_ff  <= reg_hit;
                s2_idx_ff  <= first_hit(hit);                 // see [RQ13]
                s2_addr_ff <= s1_addr_ff;
                s2_wr_ff   <= s1_wr_ff;
                s2_size_ff <= s1_size_ff;
            end
        end
    end

    // stage 3: parameter selection and check in cycle n+2
    wire  [5:0]  ctl     = busctl_ff[s2_idx_ff];              // see [RQ17]
    wire         bad     = ctl[`ERD_TYPE_MSB:0] >= `ERD_TYPE_COUNT
                        || (s2_wr_ff && ctl[`ERD_WPROT])
                        || (ctl[`ERD_BIGEND] && s2_size_ff == `ERD_SIZE_64);
    wire         go_reg  = s2_vld_ff && s2_reg_ff;
    wire         go_err  = s2_vld_ff && !s2_reg_ff
                        && (s2_miss_ff || bad);               // see [RQ19]
    wire         go_ext  = s2_vld_ff && !s2_reg_ff && !s2_miss_ff && !bad;
    wire         demux   = ctl[`ERD_TYPE_MSB:0] == ERD_DEMUX;
    wire  [31:0] ext_a   = demux                              // see [RQ11]
                        ? {8'h00, s2_addr_ff[`ERD_DEMUX_MSB:0]}
                        : s2_addr_ff;
    wire  [7:0]  cs_vec  = 8'h01 << s2_idx_ff;
    wire  [7:0]  nxt_cnt = (errcnt_ff == `ERD_ERRCNT_MAX)
                        ? errcnt_ff : errcnt_ff + 8'h01;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_start_o  <= 1'b0;
            err_ack_o    <= 1'b0;
            reg_access_o <= 1'b0;
            acc_cs_o     <= 8'h00;
        end else begin
            acc_start_o  <= go_ext;                           // see [RQ18]
            err_ack_o    <= go_err;                           // see [RQ15]
            reg_access_o <= go_reg;
            acc_cs_o     <= go_ext ? cs_vec : 8'h00;          // see [RQ3]
        end
    end

    // access parameters held until the next external access start
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_region_o <= 3'h0;
            acc_glb_cs_o <= 1'b0;
            acc_clkdiv_o <= 2'h0;
            acc_type_o   <= 3'h0;
            acc_port32_o <= 1'b0;
            acc_bigend_o <= 1'b0;
            acc_write_o  <= 1'b0;
            acc_size_o   <= 2'h0;
            acc_addr_o   <= 32'h0000_0000;
        end else if (go_ext) begin
            acc_region_o <= s2_idx_ff;
            acc_glb_cs_o <= glbcfg_ff[s2_idx_ff];             // see [RQ17]
            acc_clkdiv_o <= glbcfg_ff[`ERD_CLKDIV_MSB:`ERD_CLKDIV_LSB];
            acc_type_o   <= ctl[`ERD_TYPE_MSB:0];
            acc_port32_o <= ctl[`ERD_PORT32];
            acc_bigend_o <= ctl[`ERD_BIGEND];
            acc_write_o  <= s2_wr_ff;
            acc_size_o   <= s2_size_ff;
            acc_addr_o   <= ext_a;
        end
    end

    // one request in flight; overlap would need a hazard check on writes
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ready_ff    <= 1'b1;
            errcnt_ff   <= 8'h00;
            last_idx_ff <= 3'h0;
            last_err_ff <= 1'b0;
        end else begin
            if (accept) begin
                ready_ff <= 1'b0;
            end else if (s2_vld_ff) begin
                ready_ff <= 1'b1;
            end
            if (go_err) begin
                errcnt_ff <= nxt_cnt;
            end
            if (go_err || go_ext) begin
                last_idx_ff <= s2_idx_ff;
                last_err_ff <= go_err;
            end
        end
    end

    assign avs_readdata_o    = rdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign req_ready_o       = ready_ff;

endmodule
`default_nettype wire

// ===== hdl/erd_map.svh
// register offsets, field positions and fixed values of the region decoder
`ifndef ERD_MAP_SVH
`define ERD_MAP_SVH
`define ERD_OFS_ADDSEL    8'h00
`define ERD_OFS_BUSCTL    8'h20
`define ERD_OFS_GLBCFG    8'h40
`define ERD_OFS_STATUS    8'h44
`define ERD_REGION_ENABLE         0
`define ERD_ALTERNATE_SEGMENT_VALID         3
`define ERD_MASK_MSB      7
`define ERD_MASK_LSB      4
`define ERD_ALTERNATE_SEGMENT_MSB    11
`define ERD_ALTERNATE_SEGMENT_LSB    8
`define ERD_A_MSB         31
`define ERD_SEG_LSB       28
`define ERD_A_FIX         27
`define ERD_CMP_MSB       26
`define ERD_CMP_LSB       12
`define ERD_CMP_ALL       15'h7fff
`define ERD_DEMUX_MSB     23
`define ERD_ADDSEL_RST    32'h0000_0000
`define ERD_BUSCTL_RST    6'h00
`define ERD_GLBCFG_RST    10'h000
`define ERD_TYPE_MSB      2
`define ERD_WPROT         3
`define ERD_PORT32        4
`define ERD_BIGEND        5
`define ERD_GLBCS_MSB     7
`define ERD_CLKDIV_MSB    9
`define ERD_CLKDIV_LSB    8
`define ERD_TYPE_COUNT    3'h5
`define ERD_SIZE_64       2'h3
`define ERD_ERRCNT_MAX    8'hff
`endif

// ===== hdl/erd_pkg.sv
// types shared by the region decoder
package erd_pkg;
    typedef enum logic [2:0] {
        ERD_DEMUX,
        ERD_MUX,
        ERD_BURST_FLASH,
        ERD_SDRAM0,
        ERD_SDRAM1
    } erd_acc_e;
    typedef logic [2:0] erd_idx_t;
endpackage

// ===== testbench/erd_decoder_chk.sv
// port assertions of the region decoder
`timescale 1ns/1ns
`default_nettype none
module erd_decoder_chk (
    input wire logic        mclk_i,       // clock
    input wire logic        reset_i,      // reset
    input wire logic        req_valid_i,  // request
    input wire logic        req_ready_o,  // idle
    input wire logic [31:0] req_addr_i,   // address
    input wire logic        req_write_i,  // write
    input wire logic [1:0]  req_size_i,   // size
    input wire logic        req_local_i,  // local bus
    input wire logic        acc_start_o,  // start
    input wire logic        err_ack_o,    // error
    input wire logic        reg_access_o, // register hit
    input wire logic [2:0]  acc_region_o, // region
    input wire logic [7:0]  acc_cs_o,     // chip select
    input wire logic [2:0]  acc_type_o,   // type
    input wire logic        acc_write_o,  // write
    input wire logic [1:0]  acc_size_o,   // size
    input wire logic [31:0] acc_addr_o    // address
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_take; req_valid_i && req_ready_o; endsequence
    sequence s_done; acc_start_o || err_ack_o || reg_access_o; endsequence
    AST_ANSWER: assert property (s_take |-> ##3 s_done)
        else $error("no result three cycles after take");
    AST_READY: assert property (s_take |=> !req_ready_o [*2] ##1 req_ready_o)
        else $error("ready gap wrong");
    AST_ONE: assert property ($onehot0({acc_start_o, err_ack_o, reg_access_o}))
        else $error("two results at once");
    AST_SPUR: assert property (s_done |-> $past(req_valid_i && req_ready_o, 3))
        else $error("result without request");
    AST_CS_ON: assert property (acc_start_o |-> acc_cs_o == 8'h01 << acc_region_o)
        else $error("chip select not the region");
    AST_CS_OFF: assert property (!acc_start_o |-> acc_cs_o == 8'h00)
        else $error("chip select without start");
    AST_DEMUX: assert property (acc_start_o && acc_type_o == 3'h0 |->
        acc_addr_o == {8'h00, $past(req_addr_i[23:0], 3)}) else $error("demux address");
    AST_LOCAL: assert property (reg_access_o |-> $past(req_local_i, 3))
        else $error("register hit from system bus");
    AST_ATTR: assert property (acc_start_o |-> acc_write_o == $past(req_write_i, 3)
        && acc_size_o == $past(req_size_i, 3)) else $error("access attributes");
    AST_SEG: assert property (acc_start_o |-> $past(req_addr_i[31:28], 3)
        inside {4'h8, 4'ha, 4'hd, 4'he, 4'hf}) else $error("start outside segments");
endmodule
bind erd_decoder erd_decoder_chk u_chk (.mclk_i, .reset_i, .req_valid_i,
    .req_ready_o, .req_addr_i, .req_write_i, .req_size_i, .req_local_i,
    .acc_start_o, .err_ack_o, .reg_access_o, .acc_region_o, .acc_cs_o,
    .acc_type_o, .acc_write_o, .acc_size_o, .acc_addr_o);
`default_nettype wire

// ===== testbench/erd_master_model.sv
// on-chip bus master issuing decode requests
`timescale 1ns/1ns
`default_nettype none
module erd_master_model (
    input  wire logic   mclk_i,  // clock
    input  wire logic   ready_i, // decoder idle
    output logic        valid_o, // request
    output logic [31:0] addr_o,  // address
    output logic        write_o, // write
    output logic [1:0]  size_o,  // size
    output logic        local_o  // local bus
);
    initial begin
        valid_o = 1'b0;
        addr_o = 32'h0;
        write_o = 1'b0;
        size_o = 2'h0;
        local_o = 1'b0;
    end
    // idle address, write and local lines carry the inverse, so a stale copy can never pass
    task automatic issue(input logic [31:0] a, input logic w,
                         input logic [1:0] sz, input logic loc, input int gap);
        repeat (gap) @(posedge mclk_i);
        @(posedge mclk_i);
        valid_o <= 1'b1;
        addr_o <= a;
        write_o <= w;
        size_o <= sz;
        local_o <= loc;
        do @(posedge mclk_i); while (ready_i !== 1'b1);
        valid_o <= 1'b0;
        addr_o <= ~a;
        write_o <= ~w;
        local_o <= ~loc;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_erd_decoder.sv
// self-checking bench for the region decoder
`timescale 1ns/1ns
`default_nettype none
module tb_erd_decoder;
    logic        mclk_i = 1'b0, reset_i = 1'b1, av_rd = 1'b0, av_wr = 1'b0;
    logic [7:0]  av_a = 8'h00;
    logic [3:0]  av_be = 4'hf;
    logic [31:0] av_wd = 32'h0, av_rdat, q_a, aa, gc, sel [8], bc [8];
    logic        av_wait, q_v, q_w, q_loc, q_rdy, st, er, rg, gcs, p32, be, aw;
    logic [1:0]  q_sz, ck, asz;
    logic [2:0]  ar, ty;
    logic [7:0]  cs;
    int          n_tests = 0, n_mismatch = 0, nerr = 0;
    erd_decoder dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(av_a),
        .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
        .avs_byteenable_i(av_be), .avs_readdata_o(av_rdat),
        .avs_waitrequest_o(av_wait), .req_valid_i(q_v), .req_addr_i(q_a),
        .req_write_i(q_w), .req_size_i(q_sz), .req_local_i(q_loc),
        .req_ready_o(q_rdy), .acc_start_o(st), .err_ack_o(er),
        .reg_access_o(rg), .acc_region_o(ar), .acc_cs_o(cs), .acc_glb_cs_o(gcs),
        .acc_clkdiv_o(ck), .acc_type_o(ty), .acc_port32_o(p32),
        .acc_bigend_o(be), .acc_write_o(aw), .acc_size_o(asz), .acc_addr_o(aa));
    erd_master_model mst (.mclk_i(mclk_i), .ready_i(q_rdy), .valid_o(q_v),
        .addr_o(q_a), .write_o(q_w), .size_o(q_sz), .local_o(q_loc));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        av_wr <= w;
        av_rd <= !w;
        av_a <= a;
        av_wd <= d;
        do @(posedge mclk_i); while (av_wait !== 1'b0);
        q = av_rdat;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    // the shadow keeps only the bits each register implements
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q, m;
        m = a < 8'h20 ? 32'hffff_ffff : a < 8'h40 ? 32'h3f : 32'h3ff;
        if (a < 8'h20) sel[a[4:2]] = d & m;
        else if (a < 8'h40) bc[a[4:2]] = d & m;
        else gc = d & m;
        bus(1'b1, a, d, q);
        bus(1'b0, a, 32'h0, q);
        chk("readback", q, d & m);
    endtask
    function automatic logic hit(input int i, input logic [31:0] a);
        logic [31:0] s, cm;
        s = sel[i];
        cm = 32'h07ff_ffff & ~((32'h1 << (27 - s[7:4])) - 32'h1);
        return s[0] && ((a[31:27] == s[31:27]) || (s[3] && a[31:28] == s[11:8]
            && a[27] == s[27])) && ((a ^ s) & cm) == 32'h0;
    endfunction
    task automatic dec(input logic [31:0] a, input logic w,
                       input logic [1:0] sz, input logic loc);
        int k, r, n;
        logic [31:0] b;
        k = 1;
        r = 8;
        for (int i = 7; i >= 0; i--) if (hit(i, a)) r = i;
        b = bc[r[2:0]];
        if (r < 8 && a[31:28] inside {4'h8, 4'ha, 4'hd, 4'he, 4'hf}) k = 0;
        if (k == 0 && (b[2:0] > 3'h4 || (w && b[3]) || (b[5] && sz == 2'h3))) k = 1;
        if (loc && a[31:12] == 20'hf8000) k = 2;
        mst.issue(a, w, sz, loc, $urandom_range(2));
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while ((st | er | rg) !== 1'b1 && n < 8);
        chk("latency", n, 3);
        chk("start", st, k == 0);
        chk("error", er, k == 1);
        chk("regacc", rg, k == 2);
        if (k == 1) nerr++;
        if (k == 0) begin
            chk("region", ar, r);
            chk("cs", cs, 32'h1 << r);
            chk("addr", aa, b[2:0] == 3'h0 ? {8'h00, a[23:0]} : a);
            chk("params", {gcs, ck, ty, p32, be, aw, asz},
                {gc[r], gc[9:8], b[2:0], b[4], b[5], w, sz});
        end
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        logic [31:0] q, s, a, lo;
        void'($urandom(17));
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0, q);
            chk("reset", q, 32'h0);
            if (i < 8) sel[i] = 32'h0;
            if (i < 8) bc[i] = 32'h0;
        end
        gc = 32'h0;
        bus(1'b1, 8'h80, 32'hffff_ffff, q);
        bus(1'b0, 8'h80, 32'h0, q);
        chk("hole", q, 32'h0);
        $display("reset and map test done");
        wr(8'h00, 32'h8000_0000);
        dec(32'h8000_1234, 1'b0, 2'h2, 1'b0);
        wr(8'h04, 32'h8000_0001);
        dec(32'h8000_1234, 1'b0, 2'h2, 1'b0);
        wr(8'h04, 32'h0);
        for (int m = 0; m < 16; m++) begin
            lo = (32'h1 << (27 - m)) - 32'h1;
            s = 32'ha000_0001 | ($urandom & 32'h07ff_f000) | 32'(m << 4);
            wr(8'h00, s);
            a = (s & ~lo) | ($urandom & lo);
            dec(a, 1'b0, 2'h2, 1'b0);
            dec(a ^ (32'h1 << (27 - m)), 1'b0, 2'h2, 1'b0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'h8000_0d01 | (c[0] ? 32'h8 : 32'h0));
            dec({4'hd, c[1], 27'h5a5a5a5}, 1'b0, 2'h1, 1'b0);
        end
        $display("mask and segment test done");
        for (int i = 0; i < 8; i++) wr(8'(4 * i), 32'he000_0001);
        for (int i = 0; i < 8; i++) begin
            wr(8'(8'h20 + 4 * i), $urandom & 32'h33);
            dec(32'he765_4321, 1'b0, 2'h0, 1'b0);
            wr(8'(4 * i), 32'h0);
        end
        $display("priority test done");
        wr(8'h40, $urandom);
        // one lane only: the prescale byte is set, the rest must stay
        av_be <= 4'h2;
        bus(1'b1, 8'h40, 32'hffff_ffff, q);
        av_be <= 4'hf;
        gc = gc | 32'h300;
        bus(1'b0, 8'h40, 32'h0, q);
        chk("lanes", q, gc);
        wr(8'h00, 32'hf000_0001);
        for (int c = 0; c < 64; c++) begin
            wr(8'h20, 32'(c));
            dec(32'hf0ab_cdef, 1'($urandom), 2'($urandom), 1'b0);
        end
        dec(32'hf800_0abc, 1'b0, 2'h2, 1'b1);
        dec(32'hf800_0abc, 1'b0, 2'h2, 1'b0);
        $display("parameter test done");
        for (int i = 0; i < 100; i++) begin
            s = {4'h8 | 4'($urandom_range(7)), 28'($urandom)};
            wr(8'(4 * $urandom_range(7)), s);
            a = (sel[$urandom_range(7)] & 32'hffff_f000) ^ (32'h1 << $urandom_range(31));
            dec(a | 32'($urandom_range(4095)), 1'($urandom), 2'($urandom),
                1'($urandom));
        end
        bus(1'b1, 8'h44, 32'hffff_ffff, q);
        bus(1'b0, 8'h44, 32'h0, q);
        chk("errcount", q[7:0], nerr > 255 ? 255 : nerr);
        $display("random test done");
        finish_test;
    end
endmodule
`default_nettype wire
